// ---- sram_host_pkg.sv ----
// constants and types for the asynchronous sram write/read host controller
package sram_host_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 25;
    // least times in ns, rounded up to whole cycles below
    localparam int T_ADDR_SETUP_NS = 0;
    localparam int T_WRITE_PULSE_NS = 35;
    localparam int T_DATA_SETUP_NS = 20;
    localparam int T_DATA_HOLD_NS = 0;
    localparam int T_RECOVERY_NS = 0;
    localparam int T_READ_ACCESS_NS = 45;
    localparam int T_BUS_RELEASE_NS = 20;
    function automatic int ns_to_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int CYC_SETUP = ns_to_cycles(T_ADDR_SETUP_NS);
    localparam int CYC_PULSE_A = ns_to_cycles(T_WRITE_PULSE_NS);
    localparam int CYC_PULSE_B = ns_to_cycles(T_DATA_SETUP_NS);
    localparam int CYC_PULSE = (CYC_PULSE_A > CYC_PULSE_B) ?
                               CYC_PULSE_A : CYC_PULSE_B;
    localparam int CYC_HOLD = ns_to_cycles(T_DATA_HOLD_NS);
    localparam int CYC_RECOV = ns_to_cycles(T_RECOVERY_NS);
    localparam int CYC_ACCESS = ns_to_cycles(T_READ_ACCESS_NS);
    localparam int CYC_RELEASE = ns_to_cycles(T_BUS_RELEASE_NS);
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_RECOV, ST_RD_ACCESS,
        ST_RD_RELEASE
    } host_state_t;
endpackage

// ---- req_capture.sv ----
// one-entry request holding register with registered read port
module req_capture
    import sram_host_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              load,
    input  wire logic              load_write,
    input  wire logic [ADDR_W-1:0] load_addr,
    input  wire logic [DATA_W-1:0] load_data,
    output logic                   held_write,
    output logic [ADDR_W-1:0]      held_addr,
    output logic [DATA_W-1:0]      held_data
);
    logic              next_write;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] next_data;

    // take a new request only on load
    always_comb begin
        next_write = held_write;
        next_addr  = held_addr;
        next_data  = held_data;
        if (load) begin
            next_write = load_write;
            next_addr  = load_addr;
            next_data  = load_data;
        end
    end

    // register the held request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            held_write <= 1'b0;
            held_addr  <= '0;
            held_data  <= '0;
        end else begin
            held_write <= next_write;
            held_addr  <= next_addr;
            held_data  <= next_data;
        end
    end
endmodule

// ---- sram_host.sv ----
// host controller driving an asynchronous sram through its pins
// Function
// RQ1: write begins when last strobe becomes active
// RQ2: write ends when first strobe goes inactive
// RQ3: strobe early keeps device outputs tristated
// RQ4: host never fights device outputs in hold
// RQ5: write strobe high whenever address changes
// RQ6: high select mirrors low select, inverted
// RQ7: host keeps every input timing as minimum
// RQ8: read data sampled after maximum access time
// RQ9: write strobe held high during reads
// RQ10: addressed word stored at write end
module sram_host
    import sram_host_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic              req_enable_ctl,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   req_ready,
    output logic                   rd_valid,
    output logic [DATA_W-1:0]      rd_data,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic                   chip_select_active_low_n,
    output logic                   chip_select_active_high,
    output logic                   write_strobe_n,
    output logic                   output_enable_n,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe,
    input  wire logic [DATA_W-1:0] dq_in
);
    // assertions below sample on the core clock, off during reset
    default clocking pin_cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // request holding
    // ------------------------------------------------------------
    logic              held_write;
    logic [ADDR_W-1:0] held_addr;
    logic [DATA_W-1:0] held_data;
    logic              take;

    assign take = req_valid && req_ready;

    req_capture u_req (
        .core_clk   (core_clk),
        .rst        (rst),
        .load       (take),
        .load_write (req_write),
        .load_addr  (req_addr),
        .load_data  (req_wdata),
        .held_write (held_write),
        .held_addr  (held_addr),
        .held_data  (held_data)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    host_state_t       state, next_state;
    logic [CNT_W-1:0]  cnt, next_cnt;
    logic              en_ctl, next_en_ctl;
    logic              next_ready, next_rd_valid;
    logic [DATA_W-1:0] next_rd_data;
    logic [ADDR_W-1:0] next_addr;
    logic              next_csl_n, next_csh, next_we_n, next_oe_n;
    logic [DATA_W-1:0] next_dq_out;
    logic              next_dq_oe;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return n[CNT_W-1:0];
    endfunction

    // next pin and state values
    always_comb begin
        next_state    = state;
        next_cnt      = (cnt != CNT_ZERO) ? cnt - CNT_ONE : CNT_ZERO;
        next_en_ctl   = en_ctl;
        next_ready    = 1'b0;
        next_rd_valid = 1'b0;
        next_rd_data  = rd_data;
        next_addr     = mem_addr;
        next_csl_n    = 1'b1;
        next_csh      = 1'b0;
        next_we_n     = 1'b1;
        next_oe_n     = 1'b1;
        next_dq_out   = dq_out;
        next_dq_oe    = 1'b0;
        case (state)
            ST_IDLE: begin
                next_ready = !take;
                if (take) begin
                    // address moves only with the write strobe high; a read turns on selects and OE on the same edge
                    next_addr   = req_addr; // RQ5
                    next_en_ctl = req_enable_ctl;
                    next_cnt    = cyc(CYC_SETUP);
                    next_state  = req_write ? ST_SETUP : ST_RD_ACCESS;
                    if (!req_write) begin
                        next_csl_n = 1'b0; // RQ9
                        next_csh   = 1'b1; // RQ6
                        next_oe_n  = 1'b0;
                        next_cnt   = cyc(CYC_ACCESS);
                    end
                end
            end
            ST_SETUP: begin
                // strobe-controlled: selects first, strobe last
                next_csl_n  = en_ctl;
                next_csh    = !en_ctl; // RQ6
                next_dq_out = held_data;
                next_dq_oe  = 1'b1;
                if (cnt == CNT_ZERO) begin
                    // last edge starts the write, strobe early -> hi-z
                    next_csl_n = 1'b0; // RQ1
                    next_csh   = 1'b1; // RQ3
                    next_we_n  = 1'b0;
                    next_cnt   = cyc(CYC_PULSE - 1);
                    next_state = ST_PULSE;
                end else if (en_ctl) begin
                    next_we_n = 1'b0; // RQ3
                end
            end
            ST_PULSE: begin
                next_csl_n  = 1'b0;
                next_csh    = 1'b1;
                next_we_n   = 1'b0;
                next_dq_oe  = 1'b1;
                if (cnt == CNT_ZERO) begin
                    // first inactive edge ends the write and stores
                    next_csl_n = en_ctl ? 1'b1 : 1'b0; // RQ2
                    next_csh   = en_ctl ? 1'b0 : 1'b1; // RQ10
                    next_we_n  = en_ctl ? 1'b0 : 1'b1; // RQ2
                    next_cnt   = cyc(CYC_HOLD - 1);
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // data still driven, device outputs stay off
                next_we_n  = en_ctl ? 1'b0 : 1'b1;
                next_csl_n = en_ctl;
                next_csh   = !en_ctl;
                next_dq_oe = 1'b1; // RQ4
                if (cnt == CNT_ZERO) begin
                    next_csl_n = 1'b1;
                    next_csh   = 1'b0;
                    next_we_n  = 1'b1;
                    next_dq_oe = 1'b0;
                    next_cnt   = cyc(CYC_RECOV - 1);
                    next_state = ST_RECOV;
                end
            end
            ST_RECOV: begin
                if (cnt == CNT_ZERO) begin
                    next_ready = 1'b1; // RQ7
                    next_state = ST_IDLE;
                end
            end
            ST_RD_ACCESS: begin
                next_csl_n = 1'b0;
                next_csh   = 1'b1;
                next_oe_n  = 1'b0;
                if (cnt == CNT_ONE) begin
                    next_rd_data  = dq_in; // RQ8
                    next_rd_valid = 1'b1;
                    next_csl_n    = 1'b1;
                    next_csh      = 1'b0;
                    next_oe_n     = 1'b1;
                    next_cnt      = cyc(CYC_RELEASE);
                    next_state    = ST_RD_RELEASE;
                end
            end
            ST_RD_RELEASE: begin
                // let device outputs float before host may drive
                if (cnt == CNT_ONE || cnt == CNT_ZERO) begin
                    next_ready = 1'b1; // RQ4
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // register state and pins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state                    <= ST_IDLE;
            cnt                      <= CNT_ZERO;
            en_ctl                   <= 1'b0;
            req_ready                <= 1'b0;
            rd_valid                 <= 1'b0;
            rd_data                  <= '0;
            mem_addr                 <= '0;
            chip_select_active_low_n <= 1'b1;
            chip_select_active_high  <= 1'b0;
            write_strobe_n           <= 1'b1;
            output_enable_n          <= 1'b1;
            dq_out                   <= '0;
            dq_oe                    <= 1'b0;
        end else begin
            state                    <= next_state;
            cnt                      <= next_cnt;
            en_ctl                   <= next_en_ctl;
            req_ready                <= next_ready;
            rd_valid                 <= next_rd_valid;
            rd_data                  <= next_rd_data;
            mem_addr                 <= next_addr;
            chip_select_active_low_n <= next_csl_n;
            chip_select_active_high  <= next_csh;
            write_strobe_n           <= next_we_n;
            output_enable_n          <= next_oe_n;
            dq_out                   <= next_dq_out;
            dq_oe                    <= next_dq_oe;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic sel_on;
    logic wr_on;
    assign sel_on = !chip_select_active_low_n && chip_select_active_high;
    assign wr_on  = sel_on && !write_strobe_n;

    // pin relations kept on every cycle
    AST_SEL_MIRROR: assert property ( // RQ6
        chip_select_active_low_n == !chip_select_active_high)
        else $error("selects not mirrored");
    AST_ADDR_STABLE: assert property ( // RQ5
        $changed(mem_addr) |-> write_strobe_n && $past(write_strobe_n))
        else $error("address moved with write strobe low");
    AST_READ_NO_WE: assert property ( // RQ9
        !output_enable_n |-> write_strobe_n)
        else $error("write strobe low during read");
    AST_NO_FIGHT: assert property ( // RQ4
        dq_oe |-> output_enable_n)
        else $error("host drives while device output enabled");
    AST_HELD_WRITE: assert property ( // RQ10
        dq_oe |-> held_write)
        else $error("data driven outside a write");
    // write window edges in both styles, then read time and ready return
    AST_WRITE_START: assert property ( // RQ1
        $rose(wr_on) |-> dq_oe)
        else $error("write began without data driven");
    AST_STROBE_LAST: assert property ( // RQ1
        $rose(sel_on) && dq_oe && !en_ctl |-> write_strobe_n)
        else $error("strobe not last in strobe write");
    AST_EARLY_STROBE: assert property ( // RQ3
        $rose(sel_on) && dq_oe && en_ctl |->
        !write_strobe_n && output_enable_n)
        else $error("strobe not early at select");
    AST_PULSE_LEN: assert property ( // RQ7
        $rose(wr_on) |-> (wr_on && dq_oe) [*2])
        else $error("write pulse too short");
    AST_WRITE_END: assert property ( // RQ2
        $fell(wr_on) |-> dq_oe)
        else $error("data released before write end");
    AST_SEL_END_FIRST: assert property ( // RQ2
        $fell(wr_on) && en_ctl |-> !write_strobe_n)
        else $error("selects not first off in enable write");
    AST_STORE_DATA: assert property ( // RQ10
        $fell(wr_on) |-> dq_out == held_data)
        else $error("wrong data at write end");
    AST_READ_TIME: assert property ( // RQ8
        $fell(output_enable_n) |-> !output_enable_n [*2])
        else $error("read sampled too early");
    AST_READY_BACK: assert property (
        take |-> ##[1:12] req_ready)
        else $error("controller stuck");

    // main scenarios
    COV_WRITE_WE: cover property (take && req_write && !req_enable_ctl);
    COV_WRITE_CE: cover property (take && req_write && req_enable_ctl);
    COV_READ: cover property (rd_valid);
endmodule

// ---- sram_model.sv ----
// behavioural model of the asynchronous sram seen from the host
module sram_model
    import sram_host_pkg::*;
#(
    parameter int ACC_NS = 45
)
(
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              cs_n,
    input  wire logic              cs_h,
    input  wire logic              we_n,
    input  wire logic              oe_n,
    input  wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0]      rdata,
    output logic                   drive
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic              sel;
    logic              wr_act;
    logic              armed = 1'b0;
    wire  [DATA_W-1:0] word = mem[addr];
    wire  [DATA_W-1:0] late_q;
    // selected when the low select is low and the high select is high
    assign sel = !cs_n && cs_h;
    // write window opens on the last edge and closes on the first
    assign wr_act = sel && !we_n;
    // outputs stay off while the write strobe is low
    assign drive = sel && !oe_n && we_n;
    // wrong data shows until the full access time has run
    assign #(ACC_NS) late_q = drive ? word : ~word;
    // released bus shows the inverse so stale values never pass
    assign rdata = drive ? late_q : ~word;
    // memory starts cleared
    initial begin
        for (int i = 0; i < 2**ADDR_W; i++) begin
            mem[i] = 8'h00;
        end
    end
    // arm on a real window so the edge at reset stores nothing
    always @(posedge wr_act) begin
        armed = 1'b1;
    end
    // addressed word stored as the write window closes
    always @(negedge wr_act) begin
        if (armed) begin
            mem[addr] = wdata;
        end
        armed = 1'b0;
    end
endmodule

// ---- sram_host_tb.sv ----
// self-checking bench for the sram host controller
module sram_host_tb
    import sram_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic              core_clk;
    logic              rst;
    logic              req_valid;
    logic              req_write;
    logic              req_enable_ctl;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_wdata;
    logic              req_ready;
    logic              rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic [ADDR_W-1:0] mem_addr;
    logic              cs_n;
    logic              cs_h;
    logic              we_n;
    logic              oe_n;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
    logic [DATA_W-1:0] dq_in;
    logic              drive;
    logic [ADDR_W-1:0] last_addr;
    logic [DATA_W-1:0] ref_mem [2**ADDR_W];
    logic [31:0]       seed = 32'h1529;
    int                fails = 0;
    int                checks_done = 0;
    int                wr_len = 0;

    sram_host dut_u (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
        .req_write(req_write), .req_enable_ctl(req_enable_ctl),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .mem_addr(mem_addr),
        .chip_select_active_low_n(cs_n), .chip_select_active_high(cs_h),
        .write_strobe_n(we_n), .output_enable_n(oe_n), .dq_out(dq_out),
        .dq_oe(dq_oe), .dq_in(dq_in));
    // released host bus shows the inverse of its last value
    sram_model #(.ACC_NS(T_READ_ACCESS_NS)) sram_u (.addr(mem_addr),
        .cs_n(cs_n), .cs_h(cs_h), .we_n(we_n), .oe_n(oe_n),
        .wdata(dq_oe ? dq_out : ~dq_out), .rdata(dq_in), .drive(drive));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic report_and_stop();
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            fails++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic cmp_data(input logic [DATA_W-1:0] got,
                            input logic [DATA_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t read %h want %h", $time, got, exp);
        end
    endtask
    // bounded wait for the controller to accept a request
    task automatic wait_ready();
        int n;
        n = 0;
        while (req_ready !== 1'b1) begin
            @(negedge core_clk);
            n++;
            if (n > 50) begin
                fails++;
                report_and_stop();
            end
        end
    endtask
    // one request, held from a falling edge until taken
    task automatic issue(input logic wr, input logic ectl,
                         input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
        int n;
        wait_ready();
        req_valid = 1'b1;
        req_write = wr;
        req_enable_ctl = ectl;
        req_addr = a;
        req_wdata = d;
        @(negedge core_clk);
        req_valid = 1'b0;
        if (wr) begin
            ref_mem[a] = d;
        end else begin
            n = 0;
            while (rd_valid !== 1'b1) begin
                @(negedge core_clk);
                n++;
                if (n > 20) begin
                    fails++;
                    report_and_stop();
                end
            end
            cmp_data(rd_data, ref_mem[a]);
        end
    endtask

    // ----------------------------------------
    // pin monitor
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (!rst) begin
            check(cs_h === ~cs_n, "select polarity");
            check(!(dq_oe && drive), "data bus fight");
            check(we_n || mem_addr === last_addr, "address moved");
            check(oe_n || we_n, "strobe low in read");
            // count the write window, judge it once it closes
            if (!cs_n && cs_h && !we_n) begin
                wr_len <= wr_len + 1;
            end else if (wr_len != 0) begin
                check(wr_len * CLK_PERIOD_NS >= T_WRITE_PULSE_NS,
                      "short write");
                wr_len <= 0;
            end
        end
        last_addr <= mem_addr;
    end

    // ----------------------------------------
    // clock and sequence
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_enable_ctl = 1'b0;
        req_addr = '0;
        req_wdata = '0;
        for (int i = 0; i < 2**ADDR_W; i++) begin
            ref_mem[i] = 8'h00;
        end
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        // corner addresses, both write styles, untouched neighbour
        issue(1'b1, 1'b0, 13'h0000, 8'hA5);
        issue(1'b1, 1'b1, 13'h1FFF, 8'h5A);
        issue(1'b0, 1'b0, 13'h0000, 8'h00);
        issue(1'b0, 1'b0, 13'h1FFF, 8'h00);
        issue(1'b0, 1'b0, 13'h0001, 8'h00);
        // mid-run reset from idle: pins rest, memory contents survive
        wait_ready();
        rst = 1'b1;
        @(negedge core_clk);
        check(cs_n && !cs_h && we_n && oe_n && !dq_oe, "reset pins");
        rst = 1'b0;
        @(negedge core_clk);
        // random mix over a small window so reads hit written words
        for (int k = 0; k < 60; k++) begin
            seed = xs(seed);
            issue(seed[0], seed[1], {9'h000, seed[7:4]}, seed[15:8]);
        end
        report_and_stop();
    end
endmodule
